// ===== pcps_pkg.sv
/*
 power-state sequencer package: config offsets, field positions, timing counts, carrier types.
 assumes a 100 MHz ref_clk; config accesses arrive as a simple decoded port.
*/
package pcps_pkg;
	// config-space offset of the phy power saving control byte
	localparam logic [7:0] PHY_PWR_CTRL_OFS = 8'h98;
	localparam logic [7:0] PHY_PWR_CTRL_RST = 8'h00;
	// field positions inside that byte
	localparam int D2_SLEEP_BIT = 0;
	localparam int D3_SLEEP_BIT = 1;
	localparam int D2_FORCE_BIT = 2;
	localparam int D3_FORCE_BIT = 3;
	// pci power state encodings
	localparam logic [1:0] PS_D0 = 2'h0;
	localparam logic [1:0] PS_D1 = 2'h1;
	localparam logic [1:0] PS_D2 = 2'h2;
	localparam logic [1:0] PS_D3 = 2'h3;
	// resume timing, longest times round down
	localparam int CLK_PERIOD_NS = 10;
	localparam int DOZE_RESUME_NS = 200;
	localparam int SLEEP_RESUME_NS = 10000000;
	localparam int DOZE_RESUME_CYC = DOZE_RESUME_NS / CLK_PERIOD_NS - 1;
	localparam int SLEEP_RESUME_CYC = SLEEP_RESUME_NS / CLK_PERIOD_NS - 1;
	localparam int CARD_RESET_CYC = 4;

	typedef enum {PCPS_FULL, PCPS_DOZE, PCPS_SLEEP, PCPS_WAKE} pcps_phy_state_t;

	// phy control outputs travel together
	typedef struct packed {
		logic digital_clk_en;
		logic cable_pwr_en;
		logic pll_osc_en;
		logic repeater;
	} pcps_phy_ctrl_t;

	// config write port
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] data;
	} pcps_cfg_wr_t;
endpackage

// ===== pcps_card_pm.sv
/*
 flash-card function power behaviour: access gating, serial clock gating, auto reset, wake.
 assumes power state and card-detect inputs synchronous to ref_clk.
*/
`timescale 1ns/10ps
module pcps_card_pm #(
	parameter int RESET_CYC = pcps_pkg::CARD_RESET_CYC
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [1:0] power_state,
	input wire logic [1:0] card_detect,
	output logic full_access,
	output logic card_a_serial_clock_en,
	output logic card_b_serial_clock_en,
	output logic card_reset,
	output logic card_wake
);
	initial begin
		if (RESET_CYC < 1 || RESET_CYC > 255) $error("RESET_CYC out of range");
	end

	typedef struct packed {
		logic full;
		logic clk_en;
		logic [7:0] rst_cnt;
		logic in_d3;
		logic [1:0] det_q;
		logic wake;
		logic resetting;
		logic armed;
	} pcps_card_st_t;

	pcps_card_st_t st;
	pcps_card_st_t next_st;

	// gating and reset sequencing
	always_comb begin
		next_st = st;
		next_st.clk_en = (power_state != pcps_pkg::PS_D3);
		next_st.in_d3 = (power_state == pcps_pkg::PS_D3);
		if (st.in_d3 && power_state == pcps_pkg::PS_D0) begin
			next_st.rst_cnt = 8'(RESET_CYC);
		end else if (st.rst_cnt != 8'h00) begin
			next_st.rst_cnt = st.rst_cnt - 8'h01;
		end
		// access follows the new count, so d3 exit gives no stray cycle of access
		next_st.full = (power_state == pcps_pkg::PS_D0) && (next_st.rst_cnt == 8'h00);
		next_st.resetting = (next_st.rst_cnt != 8'h00);
		next_st.det_q = card_detect;
		next_st.armed = 1'b1;
		// any detect edge is a wake event, no clock gating on this path in aux power
		// first cycle after reset only loads the levels, so an occupied slot is no event
		next_st.wake = st.armed && |(card_detect ^ st.det_q);
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign full_access = st.full;
	assign card_a_serial_clock_en = st.clk_en;
	assign card_b_serial_clock_en = st.clk_en;
	assign card_reset = st.resetting;
	assign card_wake = st.wake;

	property p_d3_clk_off;
		@(posedge ref_clk) disable iff (rst) power_state == pcps_pkg::PS_D3 |=> !card_a_serial_clock_en;
	endproperty
	a_d3_clk_off: assert property (p_d3_clk_off) else $error("card clock running in d3hot");
	property p_d3_exit_reset;
		@(posedge ref_clk) disable iff (rst)
			$past(power_state) == pcps_pkg::PS_D3 && power_state == pcps_pkg::PS_D0 |=> ##1 card_reset;
	endproperty
	a_d3_exit_reset: assert property (p_d3_exit_reset) else $error("no auto reset on d3 exit");
	property p_lowpower_cfg_only;
		@(posedge ref_clk) disable iff (rst) power_state != pcps_pkg::PS_D0 |=> !full_access;
	endproperty
	a_lowpower_cfg_only: assert property (p_lowpower_cfg_only) else $error("full access outside d0");
	property p_detect_wake;
		@(posedge ref_clk) disable iff (rst) $changed(card_detect) |=> card_wake;
	endproperty
	a_detect_wake: assert property (p_detect_wake) else $error("detect change lost");
	property p_reset_no_access;
		@(posedge ref_clk) disable iff (rst) card_reset |-> !full_access;
	endproperty
	a_reset_no_access: assert property (p_reset_no_access) else $error("access during card reset");
endmodule

// ===== pcps_power_seq.sv
/*
 phy and card power-state sequencer top: phy doze/sleep control, linkon wake, pme.
 assumes config writes and power state arrive synchronous to ref_clk from the pci config logic.
*/
`timescale 1ns/10ps
module pcps_power_seq #(
	parameter int NUM_PORTS = 2,
	parameter int SLEEP_RESUME_CYC = pcps_pkg::SLEEP_RESUME_CYC
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire pcps_pkg::pcps_cfg_wr_t cfg_wr,
	input wire logic [7:0] cfg_rd_addr,
	output logic [7:0] cfg_rd_data,
	input wire logic [1:0] link_power_state,
	input wire logic [1:0] card_power_state,
	input wire logic [NUM_PORTS-1:0] port_idle,
	input wire logic link_on,
	input wire logic [1:0] card_detect,
	output pcps_pkg::pcps_phy_ctrl_t phy_ctrl,
	output logic pme_n,
	output logic card_full_access,
	output logic card_a_serial_clock_en,
	output logic card_b_serial_clock_en,
	output logic card_reset
);
	initial begin
		if (NUM_PORTS < 1 || NUM_PORTS > 8) $error("NUM_PORTS out of range");
		if (SLEEP_RESUME_CYC < pcps_pkg::DOZE_RESUME_CYC || SLEEP_RESUME_CYC > 2**24 - 1)
			$error("SLEEP_RESUME_CYC out of range");
	end

	typedef struct packed {
		logic [7:0] ctrl;
		pcps_pkg::pcps_phy_state_t phy;
		logic forced;
		logic [23:0] wake_cnt;
		pcps_pkg::pcps_phy_ctrl_t out;
		logic pme_n;
		logic [7:0] rd;
	} pcps_top_st_t;

	pcps_top_st_t st;
	pcps_top_st_t next_st;
	logic card_wake;
	logic card_full;
	logic card_a_en;
	logic card_b_en;
	logic card_rst;

	// phy control lines for a given phy state
	function automatic pcps_pkg::pcps_phy_ctrl_t phy_lines(input pcps_pkg::pcps_phy_state_t s, input logic rep);
		pcps_pkg::pcps_phy_ctrl_t c;
		c.digital_clk_en = (s == pcps_pkg::PCPS_FULL) || (s == pcps_pkg::PCPS_WAKE);
		c.cable_pwr_en = c.digital_clk_en;
		c.pll_osc_en = (s != pcps_pkg::PCPS_SLEEP);
		c.repeater = rep;
		return c;
	endfunction

	pcps_card_pm u_card (
		.ref_clk(ref_clk),
		.rst(rst),
		.power_state(card_power_state),
		.card_detect(card_detect),
		.full_access(card_full),
		.card_a_serial_clock_en(card_a_en),
		.card_b_serial_clock_en(card_b_en),
		.card_reset(card_rst),
		.card_wake(card_wake)
	);

	logic low_state;
	logic in_d3;
	logic ports_ok;
	logic force_on;
	logic want_sleep;
	assign in_d3 = (link_power_state == pcps_pkg::PS_D3);
	assign low_state = (link_power_state == pcps_pkg::PS_D2) || in_d3;
	assign ports_ok = &port_idle;
	assign force_on = in_d3 ? st.ctrl[pcps_pkg::D3_FORCE_BIT] : st.ctrl[pcps_pkg::D2_FORCE_BIT];
	assign want_sleep = in_d3 ? st.ctrl[pcps_pkg::D3_SLEEP_BIT] : st.ctrl[pcps_pkg::D2_SLEEP_BIT];

	// phy state machine, register file, pme
	always_comb begin
		next_st = st;
		if (cfg_wr.wr && cfg_wr.addr == pcps_pkg::PHY_PWR_CTRL_OFS) begin
			next_st.ctrl = cfg_wr.data;
		end
		next_st.rd = (cfg_rd_addr == pcps_pkg::PHY_PWR_CTRL_OFS) ? st.ctrl : 8'h00;
		// pme kept at its pin level so the output leaves a flop directly
		next_st.pme_n = ~card_wake;
		unique case (st.phy)
			pcps_pkg::PCPS_FULL: begin
				// low power only with idle ports or force; otherwise keep repeating
				if (low_state && (ports_ok || force_on)) begin
					next_st.phy = want_sleep ? pcps_pkg::PCPS_SLEEP : pcps_pkg::PCPS_DOZE;
					next_st.forced = force_on && !ports_ok;
				end
			end
			pcps_pkg::PCPS_DOZE, pcps_pkg::PCPS_SLEEP: begin
				if (!low_state) begin
					next_st.phy = pcps_pkg::PCPS_FULL;
				end else if (link_on && !st.forced) begin
					next_st.phy = pcps_pkg::PCPS_WAKE;
					next_st.wake_cnt = (st.phy == pcps_pkg::PCPS_SLEEP) ? 24'(SLEEP_RESUME_CYC)
						: 24'(pcps_pkg::DOZE_RESUME_CYC);
					next_st.pme_n = 1'b0;
				end
			end
			pcps_pkg::PCPS_WAKE: begin
				// woken phy stays up until the host returns the link to D0 or D1
				if (st.wake_cnt != 24'h000000) begin
					next_st.wake_cnt = st.wake_cnt - 24'h000001;
				end
				if (!low_state) begin
					next_st.phy = pcps_pkg::PCPS_FULL;
				end
			end
		endcase
		next_st.out = phy_lines(next_st.phy, low_state && next_st.phy == pcps_pkg::PCPS_FULL);
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st <= '{ctrl: pcps_pkg::PHY_PWR_CTRL_RST, phy: pcps_pkg::PCPS_FULL, forced: 1'b0, wake_cnt: '0,
				out: 4'hE, pme_n: 1'b1, rd: 8'h00};
		end else begin
			st <= next_st;
		end
	end

	assign cfg_rd_data = st.rd;
	assign phy_ctrl = st.out;
	assign pme_n = st.pme_n;
	assign card_full_access = card_full;
	assign card_a_serial_clock_en = card_a_en;
	assign card_b_serial_clock_en = card_b_en;
	assign card_reset = card_rst;

	sequence s_entered_unforced;
		(st.phy == pcps_pkg::PCPS_DOZE || st.phy == pcps_pkg::PCPS_SLEEP) && !st.forced;
	endsequence
	property p_linkon_wake;
		@(posedge ref_clk) disable iff (rst) s_entered_unforced ##0 (link_on && low_state) |=> !pme_n && phy_ctrl.digital_clk_en;
	endproperty
	a_linkon_wake: assert property (p_linkon_wake) else $error("linkon did not wake phy");
	property p_forced_no_wake;
		@(posedge ref_clk) disable iff (rst) st.forced && st.phy != pcps_pkg::PCPS_FULL && low_state |=> st.phy != pcps_pkg::PCPS_WAKE;
	endproperty
	a_forced_no_wake: assert property (p_forced_no_wake) else $error("forced mode woke");
	property p_busy_repeat;
		@(posedge ref_clk) disable iff (rst) st.phy == pcps_pkg::PCPS_FULL && low_state && !ports_ok && !force_on |=> phy_ctrl.repeater && phy_ctrl.digital_clk_en;
	endproperty
	a_busy_repeat: assert property (p_busy_repeat) else $error("busy ports entered low power");
	property p_d0_full;
		@(posedge ref_clk) disable iff (rst) !low_state [*2] |-> phy_ctrl.pll_osc_en && phy_ctrl.cable_pwr_en;
	endproperty
	a_d0_full: assert property (p_d0_full) else $error("phy not powered in d0/d1");
	property p_sleep_pll_off;
		@(posedge ref_clk) disable iff (rst) st.phy == pcps_pkg::PCPS_SLEEP |-> !phy_ctrl.pll_osc_en && !phy_ctrl.cable_pwr_en;
	endproperty
	a_sleep_pll_off: assert property (p_sleep_pll_off) else $error("sleep left pll running");
	property p_doze_lines;
		@(posedge ref_clk) disable iff (rst) st.phy == pcps_pkg::PCPS_DOZE |-> !phy_ctrl.digital_clk_en && phy_ctrl.pll_osc_en;
	endproperty
	a_doze_lines: assert property (p_doze_lines) else $error("doze lines wrong");
	property p_ctrl_write;
		@(posedge ref_clk) disable iff (rst) cfg_wr.wr && cfg_wr.addr == pcps_pkg::PHY_PWR_CTRL_OFS ##1 cfg_rd_addr == pcps_pkg::PHY_PWR_CTRL_OFS |=> cfg_rd_data == $past(cfg_wr.data, 2);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control byte not stored");

	// power saving entry is decided in one cycle from port status and force bits
	logic phy_low;
	assign phy_low = (st.phy == pcps_pkg::PCPS_DOZE) || (st.phy == pcps_pkg::PCPS_SLEEP);
	sequence s_entry_allowed;
		st.phy == pcps_pkg::PCPS_FULL && low_state && (ports_ok || force_on);
	endsequence
	property p_idle_entry;
		@(posedge ref_clk) disable iff (rst) s_entry_allowed ##0 ports_ok |=> phy_low && !st.forced;
	endproperty
	a_idle_entry: assert property (p_idle_entry) else $error("idle ports did not save power");
	property p_forced_entry;
		@(posedge ref_clk) disable iff (rst) s_entry_allowed ##0 !ports_ok |=> phy_low && st.forced;
	endproperty
	a_forced_entry: assert property (p_forced_entry) else $error("force bit did not save power");
	property p_mode_select;
		@(posedge ref_clk) disable iff (rst) s_entry_allowed |=>
			(st.phy == pcps_pkg::PCPS_SLEEP) == $past(want_sleep);
	endproperty
	a_mode_select: assert property (p_mode_select) else $error("wrong power saving mode");
	// a woken phy runs everything but does not repeat on its own
	property p_wake_lines;
		@(posedge ref_clk) disable iff (rst) st.phy == pcps_pkg::PCPS_WAKE |-> phy_ctrl.digital_clk_en
			&& phy_ctrl.cable_pwr_en && phy_ctrl.pll_osc_en && !phy_ctrl.repeater;
	endproperty
	a_wake_lines: assert property (p_wake_lines) else $error("woken phy not fully up");
	property p_host_return;
		@(posedge ref_clk) disable iff (rst) st.phy != pcps_pkg::PCPS_FULL && !low_state |=>
			st.phy == pcps_pkg::PCPS_FULL;
	endproperty
	a_host_return: assert property (p_host_return) else $error("phy not back to full power");
	// the resume budget loaded on wake never exceeds the sleep figure
	property p_resume_bound;
		@(posedge ref_clk) disable iff (rst) st.phy == pcps_pkg::PCPS_WAKE |->
			st.wake_cnt <= 24'(SLEEP_RESUME_CYC);
	endproperty
	a_resume_bound: assert property (p_resume_bound) else $error("resume count out of range");
endmodule

// ===== pcps_port_model.sv
/*
 far side of the phy: port status levels and the linkon event line.
 assumes the bench commands it just after a ref_clk edge.
*/
`timescale 1ns/10ps
module pcps_port_model (
	input wire logic ref_clk,
	input wire logic [1:0] idle_req,
	input wire logic wake_req,
	output logic [1:0] port_idle,
	output logic link_on
);
	// status follows one edge late, like a real port reporting; linkon follows wake_req the same way
	always_ff @(posedge ref_clk) begin
		port_idle <= idle_req;
		link_on <= wake_req;
	end
endmodule

// ===== phy_and_card_power_states_bench.sv
/*
 bench for the power-state sequencer: a table of phy cases, then wake, map, card and reset tests.
 assumes the package, design files and port model are compiled first.
*/
`timescale 1ns/10ps
module phy_and_card_power_states_bench;
	logic ref_clk = 1'h0;
	logic rst = 1'h1;
	pcps_pkg::pcps_cfg_wr_t cfg_wr = '0;
	logic [7:0] cfg_rd_addr = 8'h98;
	logic [7:0] cfg_rd_data;
	logic [1:0] lps = 2'h0;
	logic [1:0] cps = 2'h0;
	logic [1:0] idle_req = 2'h3;
	logic [1:0] card_detect = 2'h0;
	logic wake_req = 1'h0;
	logic [1:0] port_idle;
	logic link_on;
	pcps_pkg::pcps_phy_ctrl_t phy_ctrl;
	logic pme_n, acc, clk_a, clk_b, card_reset;
	int bad_count = 0;
	int num_checks = 0;
	int pme_cnt = 0;
	int crst_cnt = 0;
	int p0;
	// row: cfg byte, link state, port idle, expected phy_ctrl
	logic [15:0] rows [0:10] = '{16'h003E, 16'h0F7E, 16'h00B2, 16'h01B0, 16'h02B2, 16'h02F0,
		16'h01F2, 16'h009F, 16'h0492, 16'h0AD0, 16'h089F};

	pcps_port_model ports (.ref_clk(ref_clk), .idle_req(idle_req), .wake_req(wake_req),
		.port_idle(port_idle), .link_on(link_on));
	pcps_power_seq #(.NUM_PORTS(2), .SLEEP_RESUME_CYC(20)) uut (.ref_clk(ref_clk), .rst(rst),
		.cfg_wr(cfg_wr), .cfg_rd_addr(cfg_rd_addr), .cfg_rd_data(cfg_rd_data),
		.link_power_state(lps), .card_power_state(cps), .port_idle(port_idle),
		.link_on(link_on), .card_detect(card_detect), .phy_ctrl(phy_ctrl), .pme_n(pme_n),
		.card_full_access(acc), .card_a_serial_clock_en(clk_a), .card_b_serial_clock_en(clk_b),
		.card_reset(card_reset));

	initial begin
		forever #5 ref_clk = ~ref_clk;
	end

	// pme pulses last one cycle and card_reset four, so count their cycles as they pass
	always @(posedge ref_clk) begin
		if (!rst && pme_n === 1'h0) pme_cnt++;
		if (!rst && card_reset === 1'h1) crst_cnt++;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		cfg_wr <= '{wr: 1'h1, addr: a, data: d};
		@(posedge ref_clk);
		cfg_wr.wr <= 1'h0;
	endtask

	task automatic cfg_read(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		cfg_rd_addr <= a;
		tick(2);
		chk("cfg_rd_data", exp, cfg_rd_data);
	endtask

	// link state change, then settle
	task automatic go(input logic [1:0] s);
		@(posedge ref_clk);
		lps <= s;
		tick(4);
	endtask

	task automatic card(input logic [1:0] s, input logic [2:0] exp);
		@(posedge ref_clk);
		cps <= s;
		tick(4);
		chk("card acc/clk_a/clk_b", {5'h00, exp}, {5'h00, acc, clk_a, clk_b});
	endtask

	task automatic wake();
		p0 = pme_cnt;
		@(posedge ref_clk);
		wake_req <= 1'h1;
		@(posedge ref_clk);
		wake_req <= 1'h0;
		tick(4);
	endtask

	task automatic done_test(input string name);
		$display("test %s done, %0d checks, %0d bad", name, num_checks, bad_count);
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#200000;
		bad_count++;
		end_of_test();
	end

	initial begin
		tick(6);
		rst <= 1'h0;
		for (int i = 0; i < 11; i++) begin
			go(pcps_pkg::PS_D0);
			cfg_write(pcps_pkg::PHY_PWR_CTRL_OFS, rows[i][15:8]);
			@(posedge ref_clk);
			idle_req <= rows[i][5:4];
			tick(2);
			go(rows[i][7:6]);
			chk("phy_ctrl", {4'h0, rows[i][3:0]}, {4'h0, phy_ctrl});
			cfg_read(pcps_pkg::PHY_PWR_CTRL_OFS, rows[i][15:8]);
		end
		done_test("phy table");
		// unforced sleep: linkon wakes and pulses pme once
		go(pcps_pkg::PS_D0);
		cfg_write(pcps_pkg::PHY_PWR_CTRL_OFS, 8'h01);
		idle_req <= 2'h3;
		go(pcps_pkg::PS_D2);
		wake();
		chk("pme pulses", 8'h01, 8'(pme_cnt - p0));
		chk("phy_ctrl", 8'h0E, {4'h0, phy_ctrl});
		go(pcps_pkg::PS_D0);
		chk("phy_ctrl", 8'h0E, {4'h0, phy_ctrl});
		// forced doze with a busy port: linkon ignored
		cfg_write(pcps_pkg::PHY_PWR_CTRL_OFS, 8'h04);
		idle_req <= 2'h2;
		go(pcps_pkg::PS_D2);
		wake();
		chk("pme pulses", 8'h00, 8'(pme_cnt - p0));
		chk("phy_ctrl", 8'h02, {4'h0, phy_ctrl});
		go(pcps_pkg::PS_D0);
		chk("phy_ctrl", 8'h0E, {4'h0, phy_ctrl});
		done_test("linkon");
		// unmapped byte is not stored and reads zero
		cfg_write(8'h99, 8'hFF);
		cfg_read(8'h99, 8'h00);
		cfg_read(pcps_pkg::PHY_PWR_CTRL_OFS, 8'h04);
		done_test("map");
		card(pcps_pkg::PS_D0, 3'h7);
		card(pcps_pkg::PS_D1, 3'h3);
		card(pcps_pkg::PS_D2, 3'h3);
		card(pcps_pkg::PS_D3, 3'h0);
		p0 = pme_cnt;
		card_detect <= 2'h2;
		tick(4);
		chk("pme pulses", 8'h01, 8'(pme_cnt - p0));
		p0 = crst_cnt;
		card(pcps_pkg::PS_D0, 3'h3);
		tick(6);
		chk("card_reset cycles", 8'h04, 8'(crst_cnt - p0));
		chk("card acc/clk_a/clk_b", 8'h07, {5'h00, acc, clk_a, clk_b});
		done_test("card");
		// reset in mid-run clears the control byte and restores full power
		cfg_write(pcps_pkg::PHY_PWR_CTRL_OFS, 8'h0F);
		go(pcps_pkg::PS_D3);
		rst <= 1'h1;
		tick(2);
		chk("phy_ctrl", 8'h0E, {4'h0, phy_ctrl});
		chk("pme_n", 8'h01, {7'h00, pme_n});
		p0 = pme_cnt;
		rst <= 1'h0;
		lps <= pcps_pkg::PS_D0;
		cfg_read(pcps_pkg::PHY_PWR_CTRL_OFS, pcps_pkg::PHY_PWR_CTRL_RST);
		tick(2);
		// slot stays occupied across reset: no detect event may follow release
		chk("pme pulses", 8'h00, 8'(pme_cnt - p0));
		done_test("reset");
		end_of_test();
	end
endmodule
